// ### sfr_device.sv
// serial flash command front end: four read commands and the status byte
//
// Behaviour
// - standard read: 03h, 24-bit address, data from last address bit fall
// - fast read: 0Bh, address, 8 dummy bits, data from last dummy fall
// - dual-output read: 3Bh, address, 8 dummies, then both lines output
// - dual output: bits 7,5,3,1 on io0, bits 6,4,2,0 on io1
// - dual I/O read: BBh single, address two bits a clock, 4 dummies
// - all dummy clocks undriven so the controller can release lines
// - dual I/O data starts after last dummy, odd bits io0, even io1
// - address increments and bytes keep coming while the clock runs
// - past address 7FFFFh reading wraps to 00000h
// - chip select high ends a read; outputs undriven while deselected
// - status: busy, write latch, three protect bits, side, reserved, lock
// - status read 05h works at any time, even while busy
// - status bits go out 7 first down to 0 on falling edges
// - after bit 0 the status byte repeats while the clock runs
// - status write: 01h plus a byte, starts when chip select rises
// - busy, write latch and bit 6 ignore written values
// - protect, side and lock bits are kept as non-volatile state
// - busy stays 1 until the status write completes
// - sample on rising, drive on falling; modes 0 and 3 both work
// - address bits 23 to 19 are don't care
// - lock set and write protect low: status write ignored entirely
// - write latch cleared at power-on and when a status write completes
`timescale 1ns/1ps

module sfr_device
    import sfr_pkg::*;
#(
    parameter int WRITE_CYCLES = 5000,
    parameter logic [7:0] NV_INIT = SR_NV_INIT
) (
    // system clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // serial link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic io_line0_i,
    output logic io_line0_o,
    output logic io_line0_oe_o,
    input wire logic io_line1_i,
    output logic io_line1_o,
    output logic io_line1_oe_o,
    // array preload port
    input wire logic load_we_i,
    input wire logic [ADDR_W-1:0] load_addr_i,
    input wire logic [7:0] load_data_i,
    // status byte as seen on the system side
    output logic [7:0] status_o
);

    localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);

    // ************************************************************
    // array: written on the system clock, read on the link clock
    // ************************************************************
    logic [7:0] mem_q [0:(1<<ADDR_W)-1];

    always_ff @(posedge clock_i) begin
        if (load_we_i) begin
            mem_q[load_addr_i] <= load_data_i;
        end
    end

    // ************************************************************
    // link side, rising edge: command, address, dummy, write byte
    // ************************************************************
    sfr_state_t st_q;
    logic [4:0] cnt_q;
    logic [7:0] sh_q;
    logic [WIRE_ADDR_W-1:0] addr_sh_q;
    logic [4:0] dummy_last_q;
    logic dual_in_q;
    logic dual_q;
    logic [7:0] op_q;
    logic op_ok_q;
    logic [7:0] wdat_q;
    logic wok_q;
    logic [7:0] stat_m_q;
    logic [7:0] stat_s_q;
    logic [7:0] byte_in;

    assign byte_in = {sh_q[6:0], io_line0_i};

    // deselect is an asynchronous clear: the link clock may stop with cs high
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            st_q <= ST_OP;
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
            addr_sh_q <= 24'h000000;
            dummy_last_q <= 5'h00;
            dual_in_q <= 1'b0;
            dual_q <= 1'b0;
        end else begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 5'h01;
            case (st_q)
                ST_OP: begin
                    if (cnt_q == CNT_BYTE_LAST) begin
                        cnt_q <= 5'h00;
                        st_q <= ST_IGNORE;
                        if (byte_in == OP_READ || byte_in == OP_FAST) begin
                            st_q <= ST_ADDR;
                            dummy_last_q <= CNT_DUMMY8_LAST;
                        end else if (byte_in == OP_DOUT) begin
                            st_q <= ST_ADDR;
                            dummy_last_q <= CNT_DUMMY8_LAST;
                            dual_q <= 1'b1;
                        end else if (byte_in == OP_DIO) begin
                            st_q <= ST_ADDR;
                            dummy_last_q <= CNT_DUMMY4_LAST;
                            dual_in_q <= 1'b1;
                            dual_q <= 1'b1;
                        end else if (byte_in == OP_RDSR) begin
                            st_q <= ST_STAT;
                        end else if (byte_in == OP_WRSR) begin
                            st_q <= ST_WDAT;
                        end
                    end
                end
                ST_ADDR: begin
                    if (dual_in_q) begin
                        // odd bit on io1, even bit on io0, one pair a clock
                        addr_sh_q <= {addr_sh_q[WIRE_ADDR_W-3:0], io_line1_i, io_line0_i};
                    end else begin
                        addr_sh_q <= {addr_sh_q[WIRE_ADDR_W-2:0], io_line0_i};
                    end
                    if ((dual_in_q && cnt_q == CNT_ADDR2_LAST) ||
                        (!dual_in_q && cnt_q == CNT_ADDR1_LAST)) begin
                        cnt_q <= 5'h00;
                        st_q <= (op_q == OP_READ) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    // no drive during dummies, so the controller may turn the lines
                    if (cnt_q == dummy_last_q) begin
                        st_q <= ST_DATA;
                    end
                end
                ST_WDAT: begin
                    if (cnt_q == CNT_BYTE_LAST) begin
                        st_q <= ST_IGNORE;
                    end
                end
                default: begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // frame results held past the frame end for the system side to pick up
    always_ff @(posedge sck_i) begin
        if (st_q == ST_OP && cnt_q == 5'h00) begin
            op_ok_q <= 1'b0;
            wok_q <= 1'b0;
        end
        if (st_q == ST_OP && cnt_q == CNT_BYTE_LAST) begin
            op_q <= byte_in;
            op_ok_q <= 1'b1;
        end
        if (st_q == ST_WDAT && cnt_q == CNT_BYTE_LAST) begin
            wdat_q <= byte_in;
            wok_q <= 1'b1;
        end
    end

    // status word into the link domain; it changes only at a frame end or when an internal write completes
    always_ff @(posedge sck_i) begin
        stat_m_q <= status_o;
        stat_s_q <= stat_m_q;
    end

    // ************************************************************
    // link side, falling edge: output shifter
    // ************************************************************
    logic [ADDR_W-1:0] rd_addr_q;
    logic [ADDR_W-1:0] nxt_addr;
    logic run_q;
    logic [2:0] left_q;
    logic [7:0] ob_q;
    logic [7:0] byte_now;

    // upper wire address bits are dropped here
    assign nxt_addr = run_q ? rd_addr_q : addr_sh_q[ADDR_W-1:0];
    assign byte_now = (st_q == ST_STAT) ? stat_s_q : mem_q[nxt_addr];

    // mode 3 leading fall sees ST_OP and does nothing, so no mode latch is needed
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            io_line0_oe_o <= 1'b0;
            io_line1_oe_o <= 1'b0;
            io_line0_o <= 1'b0;
            io_line1_o <= 1'b0;
            rd_addr_q <= '0;
            run_q <= 1'b0;
            left_q <= 3'h0;
            ob_q <= 8'h00;
        end else if (st_q == ST_DATA || st_q == ST_STAT) begin
            io_line1_oe_o <= 1'b1;
            io_line0_oe_o <= dual_q;
            if (left_q == 3'h0) begin
                if (st_q == ST_DATA) begin
                    run_q <= 1'b1;
                    rd_addr_q <= nxt_addr + 1'b1;
                end
                if (dual_q) begin
                    io_line0_o <= byte_now[7];
                    io_line1_o <= byte_now[6];
                    ob_q <= {byte_now[5:0], 2'b00};
                    left_q <= LEFT_2X;
                end else begin
                    // status restarts at bit 7 on each reload
                    io_line1_o <= byte_now[7];
                    ob_q <= {byte_now[6:0], 1'b0};
                    left_q <= LEFT_1X;
                end
            end else begin
                left_q <= left_q - 3'h1;
                if (dual_q) begin
                    io_line0_o <= ob_q[7];
                    io_line1_o <= ob_q[6];
                    ob_q <= {ob_q[5:0], 2'b00};
                end else begin
                    io_line1_o <= ob_q[7];
                    ob_q <= {ob_q[6:0], 1'b0};
                end
            end
        end
    end

    // ************************************************************
    // system side: frame end, write latch and internal write
    // ************************************************************
    logic cs_m_q;
    logic cs_s_q;
    logic cs_d_q;
    logic wp_m_q;
    logic wp_s_q;
    logic cs_rise;
    logic busy_q;
    logic wel_q;
    logic [7:0] nv_q;
    logic [7:0] pend_q;
    logic [WCNT_W-1:0] wcnt_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            wp_m_q <= 1'b0;
            wp_s_q <= 1'b0;
        end else begin
            cs_m_q <= cs_n_i;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            wp_m_q <= wp_n_i;
            wp_s_q <= wp_m_q;
        end
    end

    // frame registers are stable once cs is seen high through the synchroniser
    assign cs_rise = cs_s_q && !cs_d_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            nv_q <= NV_INIT & SR_NV_MASK;
            pend_q <= 8'h00;
            wcnt_q <= '0;
        end else if (busy_q) begin
            wcnt_q <= wcnt_q - 1'b1;
            if (wcnt_q == WCNT_W'(1)) begin
                busy_q <= 1'b0;
                wel_q <= 1'b0;
                nv_q <= pend_q;
            end
        end else if (cs_rise && op_ok_q) begin
            if (op_q == OP_WREN) begin
                wel_q <= 1'b1;
            end else if (op_q == OP_WRDI) begin
                wel_q <= 1'b0;
            end else if (op_q == OP_WRSR && wok_q && wel_q &&
                         !(nv_q[SB_LOCK] && !wp_s_q)) begin
                busy_q <= 1'b1;
                wcnt_q <= WCNT_W'(WRITE_CYCLES);
                pend_q <= wdat_q & SR_NV_MASK;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_o <= NV_INIT & SR_NV_MASK;
        end else begin
            status_o <= nv_q;
            status_o[SB_BUSY] <= busy_q;
            status_o[SB_WEL] <= wel_q;
        end
    end

endmodule : sfr_device

// ### sfr_pkg.sv
// constants shared by the serial flash read and status front end
package sfr_pkg;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int ADDR_W = 19;
    localparam int WIRE_ADDR_W = 24;

    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DOUT = 8'h3B;
    localparam logic [7:0] OP_DIO = 8'hBB;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;

    // ************************************************************
    // status byte layout
    // ************************************************************
    localparam int SB_BUSY = 0;
    localparam int SB_WEL = 1;
    localparam int SB_LOCK = 7;
    localparam logic [7:0] SR_NV_MASK = 8'hBC;
    localparam logic [7:0] SR_NV_INIT = 8'h00;

    // ************************************************************
    // bit counts, as last index of each phase
    // ************************************************************
    localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
    localparam logic [4:0] CNT_ADDR1_LAST = 5'h17;
    localparam logic [4:0] CNT_ADDR2_LAST = 5'h0B;
    localparam logic [4:0] CNT_DUMMY8_LAST = 5'h07;
    localparam logic [4:0] CNT_DUMMY4_LAST = 5'h03;
    localparam logic [2:0] LEFT_1X = 3'h7;
    localparam logic [2:0] LEFT_2X = 3'h3;

    // ************************************************************
    // link-side sequencer states
    // ************************************************************
    typedef enum logic [6:0] {
        ST_OP = 7'h01,
        ST_ADDR = 7'h02,
        ST_DUMMY = 7'h04,
        ST_DATA = 7'h08,
        ST_STAT = 7'h10,
        ST_WDAT = 7'h20,
        ST_IGNORE = 7'h40
    } sfr_state_t;

endpackage : sfr_pkg

// ### sfr_device_sva.sv
// assertions on the ports of the flash front end
`timescale 1ns/1ps

module sfr_device_sva
    import sfr_pkg::*;
#(
    parameter int WRITE_CYCLES = 5000,
    parameter logic [7:0] NV_INIT = SR_NV_INIT
) (
    // system side
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic load_we_i,
    input wire logic [ADDR_W-1:0] load_addr_i,
    input wire logic [7:0] load_data_i,
    input wire logic [7:0] status_o,
    // serial link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic io_line0_i,
    input wire logic io_line0_o,
    input wire logic io_line0_oe_o,
    input wire logic io_line1_i,
    input wire logic io_line1_o,
    input wire logic io_line1_oe_o
);
    default clocking dflt @(posedge clock_i); endclocking
    default disable iff (rst_i);

    int busy_len_q;

    // counted here: a repetition of this length would not unroll
    always_ff @(posedge clock_i) begin
        if (rst_i || !status_o[SB_BUSY]) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= busy_len_q + 1;
        end
    end

    a_idle_undriven: assert property (cs_n_i |-> !io_line0_oe_o && !io_line1_oe_o)
        else $error("line driven while deselected");
    a_dual_pair: assert property (@(posedge sck_i) disable iff (cs_n_i)
        io_line0_oe_o |-> io_line1_oe_o) else $error("line 0 driven alone");
    a_reserved_zero: assert property (status_o[6] == 1'b0)
        else $error("reserved status bit set");
    a_reset_value: assert property (disable iff (1'b0)
        rst_i |=> status_o == (NV_INIT & SR_NV_MASK)) else $error("bad reset status");
    a_busy_length: assert property ($fell(status_o[SB_BUSY]) |->
        busy_len_q >= WRITE_CYCLES - 2 && busy_len_q <= WRITE_CYCLES + 2)
        else $error("busy length wrong");
    a_latch_clear: assert property ($fell(status_o[SB_BUSY]) |-> !status_o[SB_WEL])
        else $error("write latch kept after write");
    a_nv_hold: assert property ($changed(status_o & SR_NV_MASK) |->
        $fell(status_o[SB_BUSY])) else $error("stored bits changed outside write");
    a_busy_start: assert property ($rose(status_o[SB_BUSY]) |->
        status_o[SB_WEL] && cs_n_i) else $error("write started wrongly");
    a_lock_blocks: assert property ($rose(status_o[SB_BUSY]) |->
        !(status_o[SB_LOCK] && !wp_n_i)) else $error("locked status written");
endmodule : sfr_device_sva

bind sfr_device sfr_device_sva #(.WRITE_CYCLES(WRITE_CYCLES), .NV_INIT(NV_INIT)) i_sva (
    .clock_i(clock_i), .rst_i(rst_i), .load_we_i(load_we_i), .load_addr_i(load_addr_i),
    .load_data_i(load_data_i), .status_o(status_o), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .wp_n_i(wp_n_i), .io_line0_i(io_line0_i), .io_line0_o(io_line0_o),
    .io_line0_oe_o(io_line0_oe_o), .io_line1_i(io_line1_i), .io_line1_o(io_line1_o),
    .io_line1_oe_o(io_line1_oe_o)
);

// ### sfr_host_model.sv
// link controller model: mode 0, 80 ns clock running only inside frames
`timescale 1ns/1ps

module sfr_host_model (
    // serial link
    output logic sck_o,
    output logic cs_n_o,
    output logic d0_o,
    output logic d1_o,
    input wire logic q0_i,
    input wire logic q1_i
);
    // chip select rises a step after time zero: the link logic has no other
    // reset, and an edge at time zero could be missed by its processes
    initial begin
        sck_o = 1'b0;
        d0_o = 1'b0;
        d1_o = 1'b1;
        #1 cs_n_o = 1'b1;
    end

    // lines change after the fall and are taken at the rise
    task automatic tick(input logic v1, input logic v0);
        d1_o = v1;
        d0_o = v0;
        #40 sck_o = 1'b1;
        #40 sck_o = 1'b0;
    endtask : tick

    // mode 0 opcode, 1 address, 2/3 address+8 dummies (3 dual data),
    // 4 dual address+4 dummies, 5 opcode+byte a[7:0]; then nb bytes back
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int mode,
                        input int nb, output logic [7:0] rd [4]);
        logic [7:0] b;
        cs_n_o = 1'b0;
        #30;
        for (int i = 7; i >= 0; i--) tick(~d1_o, op[i]);
        for (int i = 7; i >= 0 && mode == 5; i--) tick(~d1_o, a[i]);
        for (int i = 23; i >= 0 && mode inside {[1:3]}; i--) tick(~d1_o, a[i]);
        for (int i = 11; i >= 0 && mode == 4; i--) tick(a[2*i+1], a[2*i]);
        for (int i = 0; i < 8 && mode inside {2, 3}; i++) tick(~d1_o, ~d0_o);
        // released lines shown as a toggling pattern, never a held level
        for (int i = 0; i < 4 && mode == 4; i++) tick(~d1_o, ~d0_o);
        for (int k = 0; k < nb; k++) begin
            for (int j = 7; j >= 0; j -= (mode >= 3) ? 2 : 1) begin
                d0_o = ~d0_o;
                d1_o = ~d1_o;
                #40 sck_o = 1'b1;
                b[j] = (mode >= 3) ? q0_i : q1_i;
                if (mode >= 3) b[j-1] = q1_i;
                #40 sck_o = 1'b0;
            end
            rd[k] = b;
        end
        cs_n_o = 1'b1;
        #150;
    endtask : xfer
endmodule : sfr_host_model

// ### spi_flash_read_status_test.sv
// bench: reads with wrap, dual modes, status read and write
`timescale 1ns/1ps

module spi_flash_read_status_test;
    import sfr_pkg::*;
    localparam int WC = 800;
    logic clock_i, rst_i, wp_n_i, load_we_i;
    logic [ADDR_W-1:0] load_addr_i;
    logic [7:0] load_data_i, status_o;
    logic [7:0] rd [4];
    logic [7:0] img [5] = '{8'hA5, 8'h3C, 8'h96, 8'h4B, 8'hE1};
    logic [ADDR_W-1:0] adr [5] = '{19'h7FFFE, 19'h7FFFF, 19'h00000, 19'h00001, 19'h00002};
    logic sck, cs_n, h0, h1, q0, q1, o0, o1, oe0, oe1;
    int fail_count = 0;
    int n_checks = 0;

    // wire level: the device where it drives, else the controller
    assign q0 = oe0 ? o0 : h0;
    assign q1 = oe1 ? o1 : h1;

    sfr_device #(.WRITE_CYCLES(WC)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .wp_n_i(wp_n_i),
        .io_line0_i(q0), .io_line0_o(o0), .io_line0_oe_o(oe0),
        .io_line1_i(q1), .io_line1_o(o1), .io_line1_oe_o(oe1),
        .load_we_i(load_we_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
        .status_o(status_o)
    );

    sfr_host_model i_host (
        .sck_o(sck), .cs_n_o(cs_n), .d0_o(h0), .d1_o(h1), .q0_i(q0), .q1_i(q1)
    );

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    task automatic wait_idle();
        for (int i = 0; i < WC + 50 && status_o[SB_BUSY] !== 1'b0; i++) step(1);
        if (status_o[SB_BUSY] !== 1'b0) begin
            fail_count++;
            complete_run();
        end
    endtask : wait_idle

    task automatic rd_chk(input logic [7:0] op, input logic [23:0] a, input int mode,
                          input int nb, input int first);
        i_host.xfer(op, a, mode, nb, rd);
        for (int k = 0; k < nb; k++) cmp8(rd[k], img[(first + k) % 5]);
        cmp8({6'h00, oe1, oe0}, 8'h00);
    endtask : rd_chk

    initial begin
        rst_i = 1'b1;
        wp_n_i = 1'b1;
        load_we_i = 1'b0;
        load_addr_i = '0;
        load_data_i = '0;
        step(10);
        rst_i = 1'b0;
        cmp8(status_o, 8'h00);
        for (int i = 0; i < 5; i++) begin
            load_we_i = 1'b1;
            load_addr_i = adr[i];
            load_data_i = img[i];
            step(1);
        end
        load_we_i = 1'b0;
        step(4);
        rd_chk(OP_READ, 24'hF7FFFE, 1, 4, 0);
        rd_chk(OP_FAST, 24'h000000, 2, 3, 2);
        rd_chk(OP_DOUT, 24'h07FFFF, 3, 3, 1);
        rd_chk(OP_DIO, 24'h080001, 4, 2, 3);
        i_host.xfer(OP_WREN, 24'h000000, 0, 0, rd);
        step(10);
        cmp8(status_o, 8'h02);
        i_host.xfer(OP_WRSR, 24'h0000FF, 5, 0, rd);
        step(10);
        cmp8(status_o, 8'h03);
        i_host.xfer(OP_RDSR, 24'h000000, 0, 3, rd);
        cmp8(rd[2], 8'h03);
        wait_idle();
        cmp8(status_o, 8'hBC);
        i_host.xfer(OP_RDSR, 24'h000000, 0, 3, rd);
        cmp8(rd[1], 8'hBC);
        cmp8(rd[2], 8'hBC);
        step(1);
        wp_n_i = 1'b0;
        i_host.xfer(OP_WREN, 24'h000000, 0, 0, rd);
        step(10);
        cmp8(status_o, 8'hBE);
        i_host.xfer(OP_WRSR, 24'h000000, 5, 0, rd);
        step(40);
        cmp8(status_o, 8'hBE);
        wp_n_i = 1'b1;
        step(4);
        i_host.xfer(OP_WRSR, 24'h000000, 5, 0, rd);
        step(10);
        cmp8(status_o, 8'hBF);
        wait_idle();
        cmp8(status_o, 8'h00);
        i_host.xfer(OP_WREN, 24'h000000, 0, 0, rd);
        step(10);
        cmp8(status_o, 8'h02);
        i_host.xfer(OP_WRDI, 24'h000000, 0, 0, rd);
        step(10);
        cmp8(status_o, 8'h00);
        complete_run();
    end
endmodule : spi_flash_read_status_test
